// [hdl/alu_status_flags.sv]
`timescale 1ns/1ps
// Functional notes
// - Flag-affecting op aimed at the flag register: result dropped, flags set.
// - Clear op on the flag register only sets zero, upper bits stay zero.
// - Bits 7..5 read zero; bits 4..0 readable and writable.
// - Negative flag follows the result sign bit of add, subtract, rotate and logic ops.
// - Signed overflow flag marks a wrongly changed result sign bit.
// - Zero flag set when an add, subtract, rotate, logic or clear result is zero.
// - Add and subtract: nibble carry is the carry out of bit 3.
// - Add and subtract: carry is the carry out of bit 7.
// - Subtract adds the two's complement; carries mean no borrow.
// - Rotates load nibble carry from source bit 3 or bit 4.
// - Rotates load carry with the source bit shifted out.
// - Flag register is an ordinary operand, readable and writable.
module alu_status_flags
    import asf_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire asf_op_t           coreOp,
    output logic [7:0]             resultOut,
    output logic                   resultWr,
    output logic [7:0]             flagsOut,
    input  wire logic [ASF_AW-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ASF_AW-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0]        flagsR;
    logic [7:0]        resultR;
    logic              resultWrR;
    logic [4:0]        flagsNxt;
    asf_flags_t        cur;
    asf_flags_t        opFlags;
    logic [7:0]        effA;
    logic [7:0]        opB;
    logic [7:0]        res;
    logic              affects;
    logic              isSub;
    logic              isAdd;
    logic [7:0]        addSum;
    logic              addC;
    logic              addNib;
    logic              addWrap;
    logic              awreadyR;
    logic              wreadyR;
    logic              bvalidR;
    logic [1:0]        brespR;
    logic              arreadyR;
    logic              rvalidR;
    logic [31:0]       rdataR;
    logic [1:0]        rrespR;
    logic              awHeld;
    logic              wHeld;
    logic [ASF_AW-1:0] awAddrR;
    logic [31:0]       wDataR;
    logic [3:0]        wStrbR;
    logic              doWrite;
    logic              flagsBusWr;

    function automatic asf_dec_t decode(input logic [ASF_AW-1:0] addr);
        asf_dec_t d;
        d = ASF_DEC_NONE;
        if (addr == ASF_OFF_FLAGS)
            d = ASF_DEC_FLAGS;
        else if (addr == ASF_OFF_RESULT)
            d = ASF_DEC_RESULT;
        return d;
    endfunction

    function automatic logic [7:0] bitMask(input logic [2:0] idx);
        return ASF_ONE8 << idx;
    endfunction

    // ------------------------------------------------------------
    // Operand selection and adder
    // ------------------------------------------------------------
    assign cur   = asf_flags_t'(flagsR[ASF_FLAG_TOP:0]);
    // Flag register usable as a source like any file
    assign effA  = coreOp.srcFlags ? flagsR : coreOp.opA;
    assign opB   = coreOp.opB;
    assign isSub = (coreOp.kind == ASF_SUBTRACT_FROM_LITERAL)
                || (coreOp.kind == ASF_SUBTRACT_WORKING_FILE);
    assign isAdd = (coreOp.kind == ASF_ADD_WORKING_FILE)
                || (coreOp.kind == ASF_ADD_LITERAL_WORKING);

    asf_flag_adder u_adder (
        .a      (effA),
        .b      (opB),
        .sub    (isSub),
        .sum    (addSum),
        .carry  (addC),
        .dcarry (addNib),
        .ovf    (addWrap)
    );

    // ------------------------------------------------------------
    // Result and flag evaluation
    // ------------------------------------------------------------
    always_comb
    begin
        logic setNZ;
        setNZ   = 1'b0;
        opFlags = cur;
        res     = effA;
        affects = 1'b0;
        case (coreOp.kind)
            ASF_ADD_WORKING_FILE, ASF_ADD_LITERAL_WORKING,
            ASF_SUBTRACT_FROM_LITERAL, ASF_SUBTRACT_WORKING_FILE:
            begin
                res            = addSum;
                opFlags.carry  = addC;
                opFlags.dcarry = addNib;
                opFlags.ovf    = addWrap;
                setNZ          = 1'b1;
            end
            ASF_ROTATE_LEFT_OP:
            begin
                res            = {effA[ASF_MSB-1:0], cur.carry};
                opFlags.carry  = effA[ASF_MSB];
                opFlags.dcarry = effA[ASF_NIB_LO];
                setNZ          = 1'b1;
            end
            ASF_ROTATE_RIGHT_OP:
            begin
                res            = {cur.carry, effA[ASF_MSB:1]};
                opFlags.carry  = effA[0];
                opFlags.dcarry = effA[ASF_NIB_HI];
                setNZ          = 1'b1;
            end
            ASF_CLEAR_FILE_REG:
            begin
                // Only zero moves; the rest keep their value
                res          = ASF_ZERO8;
                opFlags.zero = 1'b1;
                affects      = 1'b1;
            end
            ASF_AND_OP:
            begin
                res   = effA & opB;
                setNZ = 1'b1;
            end
            ASF_OR_OP:
            begin
                res   = effA | opB;
                setNZ = 1'b1;
            end
            ASF_XOR_OP:
            begin
                res   = effA ^ opB;
                setNZ = 1'b1;
            end
            ASF_WORKING_TO_FILE_COPY:
                res = opB;
            ASF_NIBBLE_EXCHANGE_OP:
                res = {effA[ASF_NIB_LO:0], effA[ASF_MSB:ASF_NIB_HI]};
            ASF_BIT_CLEAR_OP:
                res = effA & ~bitMask(opB[2:0]);
            ASF_BIT_SET_OP:
                res = effA | bitMask(opB[2:0]);
            default:
                res = effA;
        endcase
        if (setNZ)
        begin
            opFlags.neg  = res[ASF_MSB];
            opFlags.zero = (res == ASF_ZERO8);
            affects      = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Flag register next value
    // ------------------------------------------------------------
    // Core update wins over a bus write in the same cycle
    assign flagsBusWr = doWrite && wStrbR[ASF_LANE0]
                     && (decode(awAddrR) == ASF_DEC_FLAGS);

    always_comb
    begin
        flagsNxt = flagsR[ASF_FLAG_TOP:0];
        if (coreOp.valid && affects)
            flagsNxt = opFlags;
        else if (coreOp.valid && coreOp.destFlags)
            flagsNxt = res[ASF_FLAG_TOP:0];
        else if (flagsBusWr)
            flagsNxt = wDataR[ASF_FLAG_TOP:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            flagsR <= {ASF_PAD, ASF_FLAGS_RST};
        else
            flagsR <= {ASF_PAD, flagsNxt};
    end

    // ------------------------------------------------------------
    // Result write-back to the core
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            resultR   <= ASF_ZERO8;
            resultWrR <= 1'b0;
        end
        else
        begin
            // Flag destination never writes the computed byte back to the core
            resultWrR <= coreOp.valid && !coreOp.destFlags;
            if (coreOp.valid && !coreOp.destFlags)
                resultR <= res;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channels
    // ------------------------------------------------------------
    assign doWrite = awHeld && wHeld && !bvalidR;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            awHeld   <= 1'b0;
            awreadyR <= 1'b0;
            awAddrR  <= '0;
        end
        else if (awvalid && awreadyR)
        begin
            awHeld   <= 1'b1;
            awreadyR <= 1'b0;
            awAddrR  <= awaddr;
        end
        else if (doWrite)
            awHeld <= 1'b0;
        else if (!awHeld && !bvalidR)
            awreadyR <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wHeld   <= 1'b0;
            wreadyR <= 1'b0;
            wDataR  <= '0;
            wStrbR  <= '0;
        end
        else if (wvalid && wreadyR)
        begin
            wHeld   <= 1'b1;
            wreadyR <= 1'b0;
            wDataR  <= wdata;
            wStrbR  <= wstrb;
        end
        else if (doWrite)
            wHeld <= 1'b0;
        else if (!wHeld && !bvalidR)
            wreadyR <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            bvalidR <= 1'b0;
            brespR  <= ASF_RESP_OKAY;
        end
        else if (doWrite)
        begin
            bvalidR <= 1'b1;
            // Result register is read-only: write dropped, still OKAY
            if (decode(awAddrR) == ASF_DEC_NONE)
                brespR <= ASF_RESP_SLVERR;
            else
                brespR <= ASF_RESP_OKAY;
        end
        else if (bvalidR && bready)
            bvalidR <= 1'b0;
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channels
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            arreadyR <= 1'b0;
            rvalidR  <= 1'b0;
            rdataR   <= '0;
            rrespR   <= ASF_RESP_OKAY;
        end
        else if (arvalid && arreadyR)
        begin
            arreadyR <= 1'b0;
            rvalidR  <= 1'b1;
            rrespR   <= ASF_RESP_OKAY;
            if (decode(araddr) == ASF_DEC_FLAGS)
                rdataR <= {ASF_PAD24, flagsR};
            else if (decode(araddr) == ASF_DEC_RESULT)
                rdataR <= {ASF_PAD24, resultR};
            else
            begin
                rdataR <= '0;
                rrespR <= ASF_RESP_SLVERR;
            end
        end
        else if (rvalidR && rready)
            rvalidR <= 1'b0;
        else if (!rvalidR)
            arreadyR <= 1'b1;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign flagsOut  = flagsR;
    assign resultOut = resultR;
    assign resultWr  = resultWrR;
    assign awready   = awreadyR;
    assign wready    = wreadyR;
    assign bvalid    = bvalidR;
    assign bresp     = brespR;
    assign arready   = arreadyR;
    assign rvalid    = rvalidR;
    assign rdata     = rdataR;
    assign rresp     = rrespR;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic nibCarryRef;
    logic wrapRef;
    logic geRef;
    logic [4:0] nibSum;

    assign nibSum      = {1'b0, effA[ASF_NIB_LO:0]}
                       + {1'b0, opB[ASF_NIB_LO:0]};
    assign nibCarryRef = nibSum[ASF_NIB_HI];
    assign wrapRef     = (effA[ASF_MSB] == opB[ASF_MSB])
                      && (addSum[ASF_MSB] != effA[ASF_MSB]);
    assign geRef       = (effA >= opB);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_upper_zero;
        flagsOut[ASF_MSB:ASF_FLAG_TOP+1] == ASF_PAD;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("flag register upper bits not zero");

    property p_clear_flags;
        coreOp.valid && coreOp.destFlags
            && coreOp.kind == ASF_CLEAR_FILE_REG
        |=> cur.zero && !resultWr
            && flagsR[ASF_NIB_HI:ASF_NIB_LO] ==
               $past(flagsR[ASF_NIB_HI:ASF_NIB_LO])
            && flagsR[1:0] == $past(flagsR[1:0]);
    endproperty
    a_clear_flags: assert property (p_clear_flags)
        else $error("clear on flag register changed other flags");

    property p_drop_result;
        coreOp.valid && coreOp.destFlags && affects
        |=> !resultWr && resultOut == $past(resultOut);
    endproperty
    a_drop_result: assert property (p_drop_result)
        else $error("result written although flags were destination");

    property p_neg_sign;
        coreOp.valid && !coreOp.destFlags && (isAdd || isSub)
        |=> resultWr && cur.neg == resultOut[ASF_MSB]
            && cur.zero == (resultOut == ASF_ZERO8);
    endproperty
    a_neg_sign: assert property (p_neg_sign)
        else $error("negative or zero flag disagrees with result");

    property p_logic_zero;
        coreOp.valid && !coreOp.destFlags
            && (coreOp.kind == ASF_AND_OP || coreOp.kind == ASF_XOR_OP)
        |=> cur.zero == (resultOut == ASF_ZERO8);
    endproperty
    a_logic_zero: assert property (p_logic_zero)
        else $error("zero flag wrong after logic operation");

    property p_sub_borrow;
        coreOp.valid && isSub && !coreOp.destFlags
        |=> cur.carry == $past(geRef);
    endproperty
    a_sub_borrow: assert property (p_sub_borrow)
        else $error("carry after subtract is not no-borrow");

    property p_add_nibble;
        coreOp.valid && isAdd
        |=> cur.dcarry == $past(nibCarryRef);
    endproperty
    a_add_nibble: assert property (p_add_nibble)
        else $error("nibble carry wrong after add");

    property p_add_ovf;
        coreOp.valid && isAdd
        |=> cur.ovf == $past(wrapRef);
    endproperty
    a_add_ovf: assert property (p_add_ovf)
        else $error("signed overflow flag wrong after add");

    property p_rot_left;
        coreOp.valid && coreOp.kind == ASF_ROTATE_LEFT_OP
            && !coreOp.srcFlags
        |=> cur.carry == $past(coreOp.opA[ASF_MSB])
            && cur.dcarry == $past(coreOp.opA[ASF_NIB_LO]);
    endproperty
    a_rot_left: assert property (p_rot_left)
        else $error("rotate left loaded wrong carry flags");

    property p_flags_copy;
        coreOp.valid && coreOp.destFlags
            && coreOp.kind == ASF_WORKING_TO_FILE_COPY
        |=> flagsR[ASF_FLAG_TOP:0] == $past(opB[ASF_FLAG_TOP:0]);
    endproperty
    a_flags_copy: assert property (p_flags_copy)
        else $error("copy into flag register not stored");

endmodule

// [hdl/asf_pkg.sv]
package asf_pkg;

    // ------------------------------------------------------------
    // Register map and bus answers
    // ------------------------------------------------------------
    localparam int         ASF_AW          = 8;
    localparam logic [7:0] ASF_OFF_FLAGS   = 8'h00;
    localparam logic [7:0] ASF_OFF_RESULT  = 8'h04;
    localparam logic [1:0] ASF_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ASF_RESP_SLVERR = 2'h2;
    localparam int         ASF_LANE0       = 0;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         ASF_MSB         = 7;
    localparam int         ASF_NIB_HI      = 4;
    localparam int         ASF_NIB_LO      = 3;
    localparam int         ASF_FLAG_TOP    = 4;
    localparam logic [2:0] ASF_PAD         = 3'h0;
    localparam logic [4:0] ASF_FLAGS_RST   = 5'h00;
    localparam logic [7:0] ASF_ZERO8       = 8'h00;
    localparam logic [7:0] ASF_ONE8        = 8'h01;
    localparam logic [23:0] ASF_PAD24      = 24'h000000;

    // ------------------------------------------------------------
    // Operation kinds issued by the core
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ASF_ADD_WORKING_FILE      = 4'h0,
        ASF_ADD_LITERAL_WORKING   = 4'h1,
        ASF_SUBTRACT_FROM_LITERAL = 4'h2,
        ASF_SUBTRACT_WORKING_FILE = 4'h3,
        ASF_ROTATE_LEFT_OP        = 4'h4,
        ASF_ROTATE_RIGHT_OP       = 4'h5,
        ASF_CLEAR_FILE_REG        = 4'h6,
        ASF_AND_OP                = 4'h7,
        ASF_OR_OP                 = 4'h8,
        ASF_XOR_OP                = 4'h9,
        ASF_WORKING_TO_FILE_COPY  = 4'hA,
        ASF_FILE_TO_FILE_COPY     = 4'hB,
        ASF_NIBBLE_EXCHANGE_OP    = 4'hC,
        ASF_BIT_CLEAR_OP          = 4'hD,
        ASF_BIT_SET_OP            = 4'hE
    } asf_kind_t;

    typedef enum logic [1:0] {
        ASF_DEC_FLAGS  = 2'h0,
        ASF_DEC_RESULT = 2'h1,
        ASF_DEC_NONE   = 2'h3
    } asf_dec_t;

    typedef struct packed {
        logic neg;
        logic ovf;
        logic zero;
        logic dcarry;
        logic carry;
    } asf_flags_t;

    typedef struct packed {
        logic       valid;
        asf_kind_t  kind;
        logic [7:0] opA;
        logic [7:0] opB;
        logic       srcFlags;
        logic       destFlags;
    } asf_op_t;

endpackage

// [hdl/asf_flag_adder.sv]
`timescale 1ns/1ps
module asf_flag_adder
    import asf_pkg::*;
(
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       sub,
    output logic [7:0]      sum,
    output logic            carry,
    output logic            dcarry,
    output logic            ovf
);

    logic [7:0] bIn;
    logic [8:0] full;
    logic [4:0] low5;
    logic [7:0] low8;

    // ------------------------------------------------------------
    // Subtraction as addition of the two's complement
    // ------------------------------------------------------------
    // Carry flags come out as not-borrow for free
    assign bIn  = sub ? ~b : b;
    assign full = {1'b0, a} + {1'b0, bIn} + {8'h00, sub};
    assign low5 = {1'b0, a[ASF_NIB_LO:0]} + {1'b0, bIn[ASF_NIB_LO:0]}
                + {4'h0, sub};
    assign low8 = {1'b0, a[ASF_MSB-1:0]} + {1'b0, bIn[ASF_MSB-1:0]}
                + {7'h00, sub};

    assign sum    = full[ASF_MSB:0];
    assign carry  = full[ASF_MSB+1];
    assign dcarry = low5[ASF_NIB_HI];
    // Carry into the sign bit against carry out of it
    assign ovf    = low8[ASF_MSB] ^ full[ASF_MSB+1];

endmodule

// [verif/tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end

module tb
    import asf_pkg::*;
;
    typedef struct packed {
        logic [4:0] pre;
        asf_kind_t  kind;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] res;
        logic [4:0] flg;
    } asf_row_t;

    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    asf_op_t           coreOp = '0;
    logic [7:0]        resultOut;
    logic              resultWr;
    logic [7:0]        flagsOut;
    logic [ASF_AW-1:0] awaddr = '0;
    logic              awvalid = 1'b0;
    logic              awready;
    logic [31:0]       wdata = '0;
    logic [3:0]        wstrb = 4'hF;
    logic              wvalid = 1'b0;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              bready = 1'b0;
    logic [ASF_AW-1:0] araddr = '0;
    logic              arvalid = 1'b0;
    logic              arready;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              rvalid;
    logic              rready = 1'b0;
    logic [31:0]       rd;
    logic [1:0]        rs;
    int                errors = 0;
    int                num_checks = 0;
    asf_row_t          rows [16];

    always #25 clk = ~clk;

    alu_status_flags i_dut (
        .clk       (clk),
        .rst_n     (rst_n),
        .coreOp    (coreOp),
        .resultOut (resultOut),
        .resultWr  (resultWr),
        .flagsOut  (flagsOut),
        .awaddr    (awaddr),
        .awvalid   (awvalid),
        .awready   (awready),
        .wdata     (wdata),
        .wstrb     (wstrb),
        .wvalid    (wvalid),
        .wready    (wready),
        .bresp     (bresp),
        .bvalid    (bvalid),
        .bready    (bready),
        .araddr    (araddr),
        .arvalid   (arvalid),
        .arready   (arready),
        .rdata     (rdata),
        .rresp     (rresp),
        .rvalid    (rvalid),
        .rready    (rready)
    );

    // ------------------------------------------------------------
    // Bus and core drivers
    // ------------------------------------------------------------
    // One master for both directions; only one transfer at a time
    task automatic axi(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        if (wr)
        begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end
        else
        begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        while (!done && n < 50)
        begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            if (bvalid && bready)
            begin
                rs = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
            if (rvalid && rready)
            begin
                rs = rresp;
                rd = rdata;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) errors++;
    endtask

    task automatic op(input asf_kind_t k, input logic [7:0] a,
                      input logic [7:0] b, input logic s, input logic dst);
        @(posedge clk);
        coreOp <= '{1'b1, k, a, b, s, dst};
        @(posedge clk);
        coreOp <= '0;
        #1;
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #100000;
        errors++;
        test_done();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        rows = '{
        '{5'h00, ASF_ADD_WORKING_FILE, 8'h7F, 8'h01, 8'h80, 5'h1A},
        '{5'h00, ASF_ADD_LITERAL_WORKING, 8'hFF, 8'h01, 8'h00, 5'h07},
        '{5'h00, ASF_SUBTRACT_WORKING_FILE, 8'h05, 8'h05, 8'h00, 5'h07},
        '{5'h1F, ASF_SUBTRACT_FROM_LITERAL, 8'h00, 8'h01, 8'hFF, 5'h10},
        '{5'h00, ASF_SUBTRACT_WORKING_FILE, 8'h80, 8'h01, 8'h7F, 5'h09},
        '{5'h08, ASF_ROTATE_LEFT_OP, 8'h88, 8'h00, 8'h10, 5'h0B},
        '{5'h01, ASF_ROTATE_RIGHT_OP, 8'h11, 8'h00, 8'h88, 5'h13},
        '{5'h1B, ASF_CLEAR_FILE_REG, 8'h5A, 8'h00, 8'h00, 5'h1F},
        '{5'h0B, ASF_AND_OP, 8'hF0, 8'h0F, 8'h00, 5'h0F},
        '{5'h00, ASF_OR_OP, 8'h80, 8'h01, 8'h81, 5'h10},
        '{5'h1F, ASF_XOR_OP, 8'hAA, 8'hAA, 8'h00, 5'h0F},
        '{5'h15, ASF_WORKING_TO_FILE_COPY, 8'h00, 8'h3C, 8'h3C, 5'h15},
        '{5'h1B, ASF_FILE_TO_FILE_COPY, 8'h00, 8'h3C, 8'h00, 5'h1B},
        '{5'h0A, ASF_NIBBLE_EXCHANGE_OP, 8'hA5, 8'h00, 8'h5A, 5'h0A},
        '{5'h00, ASF_BIT_CLEAR_OP, 8'hFF, 8'h03, 8'hF7, 5'h00},
        '{5'h04, ASF_BIT_SET_OP, 8'h00, 8'h07, 8'h80, 5'h04}};
        repeat (3) @(posedge clk);
        #1;
        `CHK({flagsOut, resultOut, bvalid, rvalid}, 18'h0)
        `CHK({awready, wready, arready}, 3'h0)
        @(posedge clk);
        rst_n <= 1'b1;
        axi(1'b0, ASF_OFF_FLAGS, 32'h0);
        `CHK(rd, 32'h0)
        $display("test reset done");

        for (int i = 0; i < 16; i++)
        begin
            axi(1'b1, ASF_OFF_FLAGS, {27'h0, rows[i].pre});
            op(rows[i].kind, rows[i].a, rows[i].b, 1'b0, 1'b0);
            `CHK(resultOut, rows[i].res)
            `CHK(flagsOut, {3'h0, rows[i].flg})
            `CHK(resultWr, 1'b1)
        end
        $display("test op table done");

        // Upper bits must stay zero even when software writes ones
        axi(1'b1, ASF_OFF_FLAGS, 32'hFFFFFFFF);
        `CHK({rs, flagsOut}, {ASF_RESP_OKAY, 8'h1F})
        wstrb <= 4'h0;
        axi(1'b1, ASF_OFF_FLAGS, 32'h0);
        wstrb <= 4'hF;
        axi(1'b0, ASF_OFF_FLAGS, 32'h0);
        `CHK(rd, 32'h0000001F)
        axi(1'b1, ASF_OFF_RESULT, 32'h55);
        `CHK({rs, resultOut}, {ASF_RESP_OKAY, 8'h80})
        axi(1'b0, ASF_OFF_RESULT, 32'h0);
        `CHK({rs, rd}, {ASF_RESP_OKAY, 32'h80})
        axi(1'b0, 8'h08, 32'h0);
        `CHK({rs, rd}, {ASF_RESP_SLVERR, 32'h0})
        axi(1'b1, 8'h08, 32'h0);
        `CHK(rs, ASF_RESP_SLVERR)
        $display("test registers done");

        // Flag-affecting ops aimed at the flag register drop the result
        axi(1'b1, ASF_OFF_FLAGS, 32'h0);
        op(ASF_ADD_WORKING_FILE, 8'hFF, 8'h01, 1'b0, 1'b1);
        `CHK({resultWr, resultOut, flagsOut}, 17'h08007)
        axi(1'b1, ASF_OFF_FLAGS, 32'h1B);
        op(ASF_CLEAR_FILE_REG, 8'h00, 8'h00, 1'b0, 1'b1);
        `CHK({resultWr, resultOut, flagsOut}, 17'h0801F)
        axi(1'b1, ASF_OFF_FLAGS, 32'h0);
        op(ASF_BIT_SET_OP, 8'h00, 8'h04, 1'b1, 1'b1);
        `CHK({resultWr, flagsOut}, 9'h010)
        op(ASF_NIBBLE_EXCHANGE_OP, 8'h00, 8'h00, 1'b1, 1'b1);
        `CHK({resultWr, flagsOut}, 9'h001)
        op(ASF_ADD_WORKING_FILE, 8'h00, 8'h01, 1'b1, 1'b0);
        `CHK({resultWr, resultOut, flagsOut}, 17'h10200)
        op(ASF_WORKING_TO_FILE_COPY, 8'h00, 8'h35, 1'b0, 1'b1);
        `CHK({resultWr, resultOut, flagsOut}, 17'h00215)
        $display("test flag destination done");

        // Back to back: second op sees flags left by the first
        @(posedge clk);
        coreOp <= '{1'b1, ASF_ADD_WORKING_FILE, 8'h7F, 8'h01, 1'b0, 1'b0};
        @(posedge clk);
        coreOp <= '{1'b1, ASF_OR_OP, 8'h00, 8'h00, 1'b0, 1'b0};
        @(posedge clk);
        coreOp <= '0;
        #1;
        `CHK({resultOut, flagsOut}, 16'h000E)
        $display("test back to back done");
        test_done();
    end
endmodule
